/* File: bench/nand_flash_model.sv */
`timescale 1ns/1ps
module nand_flash_model #(
  parameter int LOAD_NS = 2000,
  parameter int CACHE_NS = 800,
  parameter int ACCESS_NS = 20
) (
  input logic ce_n,
  input logic cle,
  input logic ale,
  input logic we_n,
  input logic re_n,
  input logic [7:0] io_host,
  output logic [7:0] io_dev,
  output logic ready_busy_n
);
  logic [7:0] addr_q [4];
  logic [2:0] acnt_q = 3'h0;
  logic [15:0] cache_row_q = 16'h0;
  logic [15:0] data_row_q = 16'h0;
  logic [11:0] col_q = 12'h0;
  logic busy_q = 1'b0;
  logic cache_q = 1'b0;
  logic stat_q = 1'b0; // power-up in read mode
  initial io_dev = 8'h00;
  // Released pin reads high through its pull-up
  assign ready_busy_n = !busy_q;
  task automatic go_busy(input int ns);
    busy_q = 1'b1;
    fork
      begin
        #(ns);
        busy_q = 1'b0;
      end
    join_none
  endtask : go_busy
  // Data register moves to cache; a random fetch needs all four addresses
  task automatic take_cmd(input logic [7:0] c);
    stat_q = (c == 8'h70);
    case (c)
      8'h00, 8'h05: acnt_q = 3'h0;
      8'h30:
      begin
        cache_row_q = {addr_q[3], addr_q[2]};
        data_row_q = cache_row_q;
        col_q = {addr_q[1][3:0], addr_q[0]};
        cache_q = 1'b0;
        acnt_q = 3'h0;
        go_busy(LOAD_NS);
      end
      8'h31:
      begin
        cache_row_q = data_row_q;
        data_row_q = (acnt_q == 3'h4) ? {addr_q[3], addr_q[2]}
          : data_row_q + 16'h1;
        col_q = 12'h0;
        cache_q = 1'b1;
        acnt_q = 3'h0;
        go_busy(CACHE_NS);
      end
      8'h3F:
      begin
        cache_row_q = data_row_q;
        col_q = 12'h0;
        cache_q = 1'b0;
        go_busy(CACHE_NS);
      end
      8'hE0: col_q = {addr_q[1][3:0], addr_q[0]};
      8'hFF:
      begin
        cache_q = 1'b0;
        go_busy(ACCESS_NS * 10);
      end
      default: ;
    endcase
  endtask : take_cmd
  // Deselected chip ignores strobes; extra address bytes are dropped
  always @(posedge we_n)
  begin
    if (!ce_n && cle && (!busy_q || io_host inside {8'h70, 8'hFF}))
      take_cmd(io_host);
    else if (!ce_n && ale && !busy_q && acnt_q < 3'h4)
    begin
      addr_q[acnt_q[1:0]] = io_host;
      acnt_q = acnt_q + 3'h1;
    end
  end
  // Byte appears after the access delay; column steps per pulse
  always @(negedge re_n)
  begin
    if (!ce_n)
    begin
      #(ACCESS_NS);
      io_dev = stat_q ? {1'b0, !busy_q, !busy_q && !cache_q, 5'h00}
        : cache_row_q[7:0] ^ col_q[7:0] ^ {col_q[11:8], 4'h0};
      if (!stat_q)
        col_q = col_q + 12'h1;
    end
  end
  // No keeper on the bus: after a short hold the level flips
  always @(posedge re_n)
  begin
    #(5);
    io_dev = ~io_dev;
  end
endmodule : nand_flash_model

/* File: bench/nand_host_checker.sv */
`timescale 1ns/1ps
module nand_host_checker (
  input logic core_clk,
  input logic rstn,
  input logic ce_n,
  input logic cle,
  input logic ale,
  input logic we_n,
  input logic re_n,
  input logic [7:0] io_out,
  input logic io_oe,
  input logic ready_busy_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [2:0] acnt_q;
  // Address bytes since the last command; saturates so extras stay seen
  always_ff @(posedge core_clk)
  begin
    if (!rstn || cle)
      acnt_q <= 3'h0;
    else if (ale && !we_n && acnt_q != 3'h7)
      acnt_q <= acnt_q + 3'h1;
  end
  latch_excl_a: assert property (cle |-> !ale)
    else $error("command and address latch both high");
  we_select_a: assert property (!we_n |-> !ce_n && re_n)
    else $error("write strobe without chip enable");
  re_select_a: assert property (!re_n |-> !ce_n && !io_oe && !cle && !ale)
    else $error("read strobe while driving or latching");
  we_pulse_a: assert property ($fell(we_n) |=> we_n)
    else $error("write strobe low too long");
  re_pulse_a: assert property ($fell(re_n) |-> !re_n [*5] ##1 re_n)
    else $error("read strobe width wrong");
  latch_hold_a: assert property ($rose(we_n) |->
    $stable(io_out) && $stable(cle) && $stable(ale))
    else $error("latch or bus moved at strobe rise");
  addr_high_a: assert property (ale && !we_n && acnt_q == 3'h1
    |-> io_out[7:4] == 4'h0)
    else $error("second address byte upper nibble set");
  addr_count_a: assert property (ale && !we_n |-> acnt_q < 3'h4)
    else $error("more than four address bytes");
  busy_cmd_a: assert property (cle && !we_n && !ready_busy_n
    && $past(ready_busy_n, 4) == 1'b0 |-> io_out inside {8'h70, 8'hFF})
    else $error("command other than status or reset while busy");
  cmd_code_a: assert property (cle && !we_n |-> io_out inside
    {8'h00, 8'h30, 8'h31, 8'h3F, 8'h05, 8'hE0, 8'h70, 8'hFF})
    else $error("undefined command code");
  ce_idle_a: assert property (ce_n |-> we_n && re_n && !io_oe)
    else $error("pin activity while deselected");
  cover property ($rose(we_n) && cle && io_out == 8'h31);
  cover property ($rose(we_n) && cle && io_out == 8'h3F);
  cover property ($rose(re_n) && !ce_n);
endmodule : nand_host_checker

bind nand_host_ctrl nand_host_checker nand_host_checker_inst (.core_clk,
  .rstn, .ce_n, .cle, .ale, .we_n, .re_n, .io_out, .io_oe, .ready_busy_n);

/* File: bench/nand_host_ctrl_tb_top.sv */
`timescale 1ns/1ps
module nand_host_ctrl_tb_top;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic [7:0] sw_addr = 8'h00;
  logic [31:0] sw_wdata = 32'h0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic ce_n, cle, ale, we_n, re_n, wp_n, io_oe, ready_busy_n;
  logic [7:0] io_out, io_in, io_dev;
  logic [31:0] rdat;
  int num_errors = 0;
  int samples_checked = 0;
  always #20 core_clk = ~core_clk;
  // Bus level: the controller wins only while it drives
  assign io_in = io_oe ? io_out : io_dev;
  nand_host_ctrl nand_host_ctrl_inst (.core_clk, .rstn, .clk_en, .sw_addr,
    .sw_wdata, .sw_wr, .sw_rd, .sw_rdata, .ce_n, .cle, .ale, .we_n, .re_n,
    .wp_n, .io_out, .io_oe, .io_in, .ready_busy_n);
  nand_flash_model nand_flash_model_inst (.ce_n, .cle, .ale, .we_n, .re_n,
    .io_host(io_out), .io_dev, .ready_busy_n);
  function automatic logic [7:0] pb(input logic [15:0] r, input logic [11:0] c);
    return r[7:0] ^ c[7:0] ^ {c[11:8], 4'h0};
  endfunction : pb
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task automatic check_value(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_value
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd_check(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] exp);
    @(posedge core_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    @(negedge core_clk);
    rdat = sw_rdata;
    if (m != 32'h0)
      check_value(rdat & m, exp);
  endtask : rd_check
  // Polls busy with a bound so a stuck flash cannot hang the run
  task automatic wait_idle();
    int n;
    n = 0;
    rdat = 32'h1;
    while (rdat[0] !== 1'b0 && n < 500)
    begin
      rd_check(nand_host_pkg::OFS_STATUS, 32'h0, 32'h0);
      n++;
    end
    check_value({31'h0, rdat[0]}, 32'h0);
  endtask : wait_idle
  task automatic run_op(input nand_host_pkg::op_type op);
    wr(nand_host_pkg::OFS_OP, 32'(op));
    wait_idle();
  endtask : run_op
  task automatic read_byte(input logic [7:0] exp);
    run_op(nand_host_pkg::OP_READ_BYTE);
    rd_check(nand_host_pkg::OFS_DATA, 32'hFF, {24'h0, exp});
  endtask : read_byte
  task automatic status_is(input logic [31:0] m, input logic [31:0] exp);
    rd_check(nand_host_pkg::OFS_STATUS, m, exp);
  endtask : status_is
  initial
  begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(negedge core_clk);
    check_value({31'h0, wp_n}, 32'h0);
    rd_check(nand_host_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0);
    status_is(32'hF, 32'h2);
    rd_check(8'h3C, 32'hFFFFFFFF, 32'h0);
    wr(nand_host_pkg::OFS_CTRL, 32'h1);
    @(negedge core_clk);
    check_value({31'h0, wp_n}, 32'h1);
    wr(nand_host_pkg::OFS_CTRL, 32'h0);
    clk_en <= 1'b0;
    wr(nand_host_pkg::OFS_CTRL, 32'h1);
    clk_en <= 1'b1;
    @(negedge core_clk);
    check_value({31'h0, wp_n}, 32'h0);
    $display("test reset done");
    wr(nand_host_pkg::OFS_COL, 32'h7FE);
    wr(nand_host_pkg::OFS_ROW, 32'h0123);
    run_op(nand_host_pkg::OP_PAGE_READ);
    for (int i = 0; i < 3; i++)
      read_byte(pb(16'h0123, 12'h7FE + 12'(i)));
    wr(nand_host_pkg::OFS_COL, 32'h010);
    run_op(nand_host_pkg::OP_COL_CHANGE);
    read_byte(pb(16'h0123, 12'h010));
    wr(nand_host_pkg::OFS_COL, 32'h840);
    run_op(nand_host_pkg::OP_COL_CHANGE);
    status_is(32'h8, 32'h8);
    wr(nand_host_pkg::OFS_STATUS, 32'h8);
    status_is(32'h8, 32'h0);
    run_op(nand_host_pkg::OP_STATUS);
    status_is(32'hFF04, 32'h6004);
    read_byte(pb(16'h0123, 12'h011));
    $display("test page read done");
    wr(nand_host_pkg::OFS_ROW, 32'h0200);
    run_op(nand_host_pkg::OP_RAND_CACHE);
    run_op(nand_host_pkg::OP_STATUS);
    status_is(32'hFF00, 32'h4000);
    read_byte(pb(16'h0123, 12'h000));
    run_op(nand_host_pkg::OP_SEQ_CACHE);
    read_byte(pb(16'h0200, 12'h000));
    read_byte(pb(16'h0200, 12'h001));
    run_op(nand_host_pkg::OP_LAST_CACHE);
    read_byte(pb(16'h0201, 12'h000));
    run_op(nand_host_pkg::OP_STATUS);
    status_is(32'hFF00, 32'h6000);
    $display("test cache read done");
    run_op(nand_host_pkg::OP_RESET);
    wr(nand_host_pkg::OFS_COL, 32'h005);
    wr(nand_host_pkg::OFS_OP, 32'(nand_host_pkg::OP_PAGE_READ));
    wr(nand_host_pkg::OFS_OP, 32'(nand_host_pkg::OP_PAGE_READ));
    wait_idle();
    status_is(32'h8, 32'h8);
    read_byte(pb(16'h0200, 12'h005));
    $display("test reset and refusal done");
    complete_run();
  end
  // Tests need well under a thousand cycles; this allows 20000, over twenty times that
  initial
  begin
    #(800000);
    num_errors++;
    complete_run();
  end
endmodule : nand_host_ctrl_tb_top

/* File: hw/nand_cycle_engine.sv */
`timescale 1ns/1ps
module nand_cycle_engine (
  input logic core_clk,
  input logic rstn,
  input logic clk_en,
  nand_cycle_if.eng bus,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic [7:0] io_out,
  output logic io_oe
);

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_STROBE = 2'b01,
    E_HOLD = 2'b10,
    E_READ = 2'b11
  } eng_state_type;

  localparam logic [3:0] WE_LAST =
    4'(nand_host_pkg::WE_PULSE_CYC - 1);
  // Access delay plus synchroniser latency before the byte is trusted;
  // the agreeing output only settles one edge after the third stage fills
  localparam logic [3:0] RD_LAST =
    4'(nand_host_pkg::READ_ACCESS_CYC + nand_host_pkg::SYNC_STAGES);

  eng_state_type state_q;
  logic [3:0] cnt_q;

  // Strobe timing for one command, address or read cycle
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_q <= E_IDLE;
      cnt_q <= 4'h0;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_out <= 8'h00;
      io_oe <= 1'b0;
      bus.done <= 1'b0;
      bus.rbyte <= 8'h00;
    end
    else if (clk_en)
    begin
      bus.done <= 1'b0;
      unique case (state_q)
        E_IDLE:
        begin
          if (bus.req)
          begin
            if (bus.kind == nand_host_pkg::CYC_READ)
            begin
              re_n <= 1'b0; // R1
              cnt_q <= RD_LAST;
              state_q <= E_READ;
            end
            else
            begin
              cle <= (bus.kind == nand_host_pkg::CYC_CMD); // R3
              ale <= (bus.kind == nand_host_pkg::CYC_ADDR); // R2
              io_out <= bus.wbyte;
              io_oe <= 1'b1;
              we_n <= 1'b0;
              cnt_q <= WE_LAST;
              state_q <= E_STROBE;
            end
          end
        end
        E_STROBE:
        begin
          // Latch edge; latch enables and data held one cycle past it
          if (cnt_q == 4'h0)
          begin
            we_n <= 1'b1; // R25
            state_q <= E_HOLD;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
        E_HOLD:
        begin
          cle <= 1'b0;
          ale <= 1'b0;
          io_oe <= 1'b0;
          bus.done <= 1'b1;
          state_q <= E_IDLE;
        end
        E_READ:
        begin
          if (cnt_q == 4'h0)
          begin
            bus.rbyte <= bus.io_sync;
            re_n <= 1'b1;
            bus.done <= 1'b1;
            state_q <= E_IDLE;
          end
          else
            cnt_q <= cnt_q - 4'h1;
        end
      endcase
    end
  end

endmodule : nand_cycle_engine

/* File: hw/nand_cycle_if.sv */
`timescale 1ns/1ps
// One bus cycle request from the sequencer to the pin engine
interface nand_cycle_if;
  logic req;
  nand_host_pkg::cyc_kind_type kind;
  logic [7:0] wbyte;
  logic [7:0] io_sync;
  logic done;
  logic [7:0] rbyte;

  modport seq (output req, output kind, output wbyte, output io_sync,
    input done, input rbyte);
  modport eng (input req, input kind, input wbyte, input io_sync,
    output done, output rbyte);
endinterface : nand_cycle_if

/* File: hw/nand_host_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// R1: Each read strobe pulse fetches the next byte; column advances per pulse.
// R2: Latch address bytes with address latch high on write strobe rise.
// R3: Latch command bytes with command latch high on write strobe rise.
// R4: Write protect low blocks program and erase; driven from a control bit.
// R5: Ready-busy low while array work runs; high once it completes.
// R6: Address is four bytes: column low, column high, row low, row high.
// R7: Upper four bits of the second address byte are driven low.
// R8: Extra address bytes beyond four are ignored by the flash.
// R9: While busy only status query and reset commands are issued.
// R10: Only defined command codes are ever placed on the bus.
// R11: Column change is refused for columns outside the loaded page.
// R12: Flash starts in read mode; first read needs no setup command.
// R13: Page read is 00h, four addresses, 30h, then busy for load time.
// R14: After a status query, reissue 00h before reading data bytes.
// R15: Data comes out sequentially from the start column to page end.
// R16: Cache and data registers work independently of each other.
// R17: Cache read begins with an ordinary 00h-30h page read.
// R18: Command 31h fetches the next page while the cache stays readable.
// R19: 00h, four addresses, 31h fetches a chosen page into the data register.
// R20: Each continuing cache read holds ready-busy low for the cache time.
// R21: Status bits 6:5 read 00 while cache-busy, 10 once data ready.
// R22: After a cache transfer output starts at column 0 unless changed.
// R23: Command 3Fh copies data to cache without another array fetch.
// R24: Chip enable high means the flash ignores the bus and floats it.
// R25: Command, address and data bytes are captured on write strobe rise.
// R26: After 3Fh completes, status bits 6:5 both read 1.
// R27: Load time and cache busy time are settable on the flash model.
module nand_host_ctrl (
  input logic core_clk,
  input logic rstn,
  input logic clk_en,
  input logic [7:0] sw_addr,
  input logic [31:0] sw_wdata,
  input logic sw_wr,
  input logic sw_rd,
  output logic [31:0] sw_rdata,
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic re_n,
  output logic wp_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input logic [7:0] io_in,
  input logic ready_busy_n
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_PRE = 3'b001,
    S_ADDR = 3'b010,
    S_POST = 3'b011,
    S_ONSET = 3'b100,
    S_WAIT_RDY = 3'b101,
    S_READ = 3'b110
  } state_type;

  localparam logic [2:0] ONSET_LAST =
    3'(nand_host_pkg::BUSY_ONSET_CYC - 1);

  nand_cycle_if cyc ();

  state_type state_q;
  nand_host_pkg::plan_type plan_q;
  nand_host_pkg::plan_type new_plan;
  nand_host_pkg::op_type new_op;
  logic [2:0] addr_idx_q;
  logic [2:0] onset_cnt_q;
  logic issued_q;
  logic req_q;
  logic [11:0] col_q;
  logic [15:0] row_q;
  logic err_q;
  logic reread_q;
  logic [7:0] status_byte_q;
  logic [7:0] data_q;
  logic [8:0] pins_sync;
  logic flash_ready;
  logic op_write;
  logic start_ok;
  logic start_bad;

  // Next step of an operation, skipping steps the plan does not use
  function automatic state_type step_after(input state_type s,
    input nand_host_pkg::plan_type p);
    state_type n;
    n = S_IDLE;
    if (s == S_ONSET)
      n = S_WAIT_RDY;
    else if (s == S_IDLE && p.pre_en)
      n = S_PRE;
    else if ((s == S_IDLE || s == S_PRE) && p.naddr != 3'h0)
      n = S_ADDR;
    else if ((s == S_IDLE || s == S_PRE || s == S_ADDR) && p.post_en)
      n = S_POST;
    else if (s != S_WAIT_RDY && s != S_READ && p.wait_rdy)
      n = S_ONSET;
    else if (s != S_READ && p.rd_byte)
      n = S_READ;
    return n;
  endfunction : step_after

  // Address byte order: column low, column high, row low, row high
  function automatic logic [7:0] addr_byte(input logic [2:0] idx,
    input logic [11:0] col, input logic [15:0] row);
    logic [7:0] b;
    b = col[7:0];
    unique case (idx)
      3'h1: b = {4'h0, col[11:8]}; // R7
      3'h2: b = row[7:0];
      3'h3: b = row[15:8];
      default: b = col[7:0];
    endcase
    return b;
  endfunction : addr_byte

  // Ready-busy and the data bus arrive asynchronously
  nand_pin_sync #(
    .WIDTH(9)
  ) u_sync (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .pin_in({ready_busy_n, io_in}),
    .pin_out(pins_sync)
  );

  nand_cycle_engine u_engine (
    .core_clk(core_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .bus(cyc.eng),
    .cle(cle),
    .ale(ale),
    .we_n(we_n),
    .re_n(re_n),
    .io_out(io_out),
    .io_oe(io_oe)
  );

  assign flash_ready = pins_sync[8]; // R5
  assign cyc.io_sync = pins_sync[7:0];
  assign cyc.req = req_q;

  // Start checks on a write to the operation register
  always_comb
  begin
    new_op = nand_host_pkg::op_type'(sw_wdata[2:0]);
    new_plan = nand_host_pkg::op_plan(new_op, reread_q); // R14
    op_write = sw_wr && sw_addr == nand_host_pkg::OFS_OP;
    start_ok = op_write && state_q == S_IDLE
      && (flash_ready || new_op == nand_host_pkg::OP_STATUS
        || new_op == nand_host_pkg::OP_RESET) // R9
      && !(new_op == nand_host_pkg::OP_COL_CHANGE
        && col_q >= nand_host_pkg::PAGE_BYTES); // R11
    start_bad = op_write && !start_ok;
  end

  // Cycle kind and byte for the step in progress
  always_comb
  begin
    cyc.kind = nand_host_pkg::CYC_CMD;
    cyc.wbyte = plan_q.pre_code; // R10
    unique case (state_q)
      S_ADDR:
      begin
        cyc.kind = nand_host_pkg::CYC_ADDR;
        cyc.wbyte = addr_byte(addr_idx_q, col_q, row_q); // R6
      end
      S_POST: cyc.wbyte = plan_q.post_code;
      S_READ: cyc.kind = nand_host_pkg::CYC_READ;
      default: cyc.wbyte = plan_q.pre_code;
    endcase
  end

  // Operation sequencer
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_q <= S_IDLE;
      plan_q <= '0;
      addr_idx_q <= 3'h0;
      onset_cnt_q <= 3'h0;
      issued_q <= 1'b0;
      req_q <= 1'b0;
      ce_n <= 1'b1;
    end
    else if (clk_en)
    begin
      req_q <= 1'b0;
      unique case (state_q)
        S_IDLE:
        begin
          ce_n <= 1'b1; // R24
          addr_idx_q <= 3'h0;
          if (start_ok)
          begin
            plan_q <= new_plan;
            ce_n <= 1'b0;
            state_q <= step_after(S_IDLE, new_plan);
          end
        end
        S_ONSET:
        begin
          // Ready-busy falls only some time after the last command
          if (onset_cnt_q == 3'h0)
            state_q <= step_after(S_ONSET, plan_q);
          else
            onset_cnt_q <= onset_cnt_q - 3'h1;
        end
        S_WAIT_RDY:
        begin
          if (flash_ready) // R5
            state_q <= step_after(S_WAIT_RDY, plan_q);
        end
        default:
        begin
          // One engine cycle per step, one per byte in S_ADDR: request once, wait for done
          if (!issued_q)
          begin
            req_q <= 1'b1;
            issued_q <= 1'b1;
          end
          else if (cyc.done)
          begin
            issued_q <= 1'b0;
            onset_cnt_q <= ONSET_LAST;
            if (state_q == S_ADDR && addr_idx_q != plan_q.naddr - 3'h1)
              addr_idx_q <= addr_idx_q + 3'h1; // R6
            else
              state_q <= step_after(state_q, plan_q); // R13
          end
        end
      endcase
    end
  end

  // Read-back bytes and the reissue-read flag
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      status_byte_q <= 8'h00;
      data_q <= 8'h00;
      reread_q <= 1'b0;
    end
    else if (clk_en && cyc.done)
    begin
      if (state_q == S_READ && plan_q.pre_code == nand_host_pkg::CMD_STATUS)
      begin
        status_byte_q <= cyc.rbyte; // R21
        reread_q <= 1'b1; // R14
      end
      else if (state_q == S_READ)
        data_q <= cyc.rbyte; // R15
      else if (state_q == S_PRE
        && plan_q.pre_code == nand_host_pkg::CMD_READ_SETUP)
        reread_q <= 1'b0; // R14
    end
  end

  // Software-written settings
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      col_q <= nand_host_pkg::COL_RESET;
      row_q <= nand_host_pkg::ROW_RESET;
      wp_n <= nand_host_pkg::WP_N_RESET;
    end
    else if (clk_en && sw_wr && state_q == S_IDLE)
    begin
      // Address changes mid-operation would corrupt the cycle bytes
      if (sw_addr == nand_host_pkg::OFS_COL)
        col_q <= sw_wdata[11:0];
      if (sw_addr == nand_host_pkg::OFS_ROW)
        row_q <= sw_wdata[15:0];
      if (sw_addr == nand_host_pkg::OFS_CTRL)
        wp_n <= sw_wdata[nand_host_pkg::CTRL_WP_RELEASE_BIT]; // R4
    end
  end

  // Refused-start flag; a new refusal beats a clear
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      err_q <= 1'b0;
    else if (clk_en)
    begin
      if (start_bad)
        err_q <= 1'b1;
      else if (sw_wr && sw_addr == nand_host_pkg::OFS_STATUS
        && sw_wdata[nand_host_pkg::ST_ERR_BIT])
        err_q <= 1'b0;
    end
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      sw_rdata <= 32'h0000_0000;
    else if (clk_en)
    begin
      sw_rdata <= 32'h0000_0000;
      if (sw_rd)
      begin
        unique case (sw_addr)
          nand_host_pkg::OFS_COL: sw_rdata <= {20'h0_0000, col_q};
          nand_host_pkg::OFS_ROW: sw_rdata <= {16'h0000, row_q};
          nand_host_pkg::OFS_CTRL: sw_rdata <= {31'h0000_0000, wp_n};
          nand_host_pkg::OFS_STATUS:
            sw_rdata <= {16'h0000, status_byte_q, 4'h0, err_q, reread_q,
              flash_ready, state_q != S_IDLE};
          nand_host_pkg::OFS_DATA: sw_rdata <= {24'h00_0000, data_q};
          default: sw_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : nand_host_ctrl

/* File: hw/nand_host_pkg.sv */
package nand_host_pkg;

  // Core clock
  localparam int CLK_PERIOD_NS = 40;

  // Pin timing, in nanoseconds, and derived cycle counts (rounded up)
  localparam int WE_PULSE_NS = 12;
  localparam int WE_PULSE_CYC =
    (WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int READ_ACCESS_DELAY_NS = 20;
  localparam int READ_ACCESS_CYC =
    (READ_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_ONSET_NS = 100;
  localparam int BUSY_ONSET_CYC =
    (BUSY_ONSET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 3;

  // Page geometry: 2048 data bytes plus 64 spare bytes
  localparam logic [11:0] PAGE_BYTES = 12'h840;
  localparam int ADDR_CYCLES = 4;

  // Software register offsets
  localparam logic [7:0] OFS_OP = 8'h00;
  localparam logic [7:0] OFS_COL = 8'h04;
  localparam logic [7:0] OFS_ROW = 8'h08;
  localparam logic [7:0] OFS_CTRL = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_DATA = 8'h14;

  // Field positions
  localparam int CTRL_WP_RELEASE_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_REREAD_BIT = 2;
  localparam int ST_ERR_BIT = 3;
  localparam int ST_BYTE_LSB = 8;

  // Reset values
  localparam logic WP_N_RESET = 1'b0;
  localparam logic [11:0] COL_RESET = 12'h000;
  localparam logic [15:0] ROW_RESET = 16'h0000;

  // Command codes presented to the flash
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_CACHE_NEXT = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3F;
  localparam logic [7:0] CMD_COL_SETUP = 8'h05;
  localparam logic [7:0] CMD_COL_GO = 8'hE0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;

  // Operations software can start
  typedef enum logic [2:0] {
    OP_PAGE_READ = 3'b000,
    OP_RAND_CACHE = 3'b001,
    OP_SEQ_CACHE = 3'b010,
    OP_LAST_CACHE = 3'b011,
    OP_COL_CHANGE = 3'b100,
    OP_STATUS = 3'b101,
    OP_RESET = 3'b110,
    OP_READ_BYTE = 3'b111
  } op_type;

  // Kinds of single bus cycle
  typedef enum logic [1:0] {
    CYC_CMD = 2'b00,
    CYC_ADDR = 2'b01,
    CYC_READ = 2'b10
  } cyc_kind_type;

  // Steps of one operation
  typedef struct packed {
    logic pre_en;
    logic [7:0] pre_code;
    logic [2:0] naddr;
    logic post_en;
    logic [7:0] post_code;
    logic wait_rdy;
    logic rd_byte;
  } plan_type;

  // Expands an operation into its command, address and data steps
  function automatic plan_type op_plan(input op_type op, input logic reread);
    plan_type p;
    p = '{1'b1, CMD_READ_SETUP, 3'h0, 1'b0, CMD_READ_GO, 1'b0, 1'b0};
    unique case (op)
      OP_PAGE_READ:
      begin
        p.naddr = 3'h4;
        p.post_en = 1'b1;
        p.wait_rdy = 1'b1;
      end
      OP_RAND_CACHE:
      begin
        p.naddr = 3'h4;
        p.post_en = 1'b1;
        p.post_code = CMD_CACHE_NEXT;
        p.wait_rdy = 1'b1;
      end
      OP_SEQ_CACHE:
      begin
        p.pre_code = CMD_CACHE_NEXT;
        p.wait_rdy = 1'b1;
      end
      OP_LAST_CACHE:
      begin
        p.pre_code = CMD_CACHE_LAST;
        p.wait_rdy = 1'b1;
      end
      OP_COL_CHANGE:
      begin
        p.pre_code = CMD_COL_SETUP;
        p.naddr = 3'h2;
        p.post_en = 1'b1;
        p.post_code = CMD_COL_GO;
      end
      OP_STATUS:
      begin
        p.pre_code = CMD_STATUS;
        p.rd_byte = 1'b1;
      end
      OP_RESET:
      begin
        p.pre_code = CMD_RESET;
        p.wait_rdy = 1'b1;
      end
      OP_READ_BYTE:
      begin
        p.pre_en = reread;
        p.rd_byte = 1'b1;
      end
    endcase
    return p;
  endfunction : op_plan

endpackage : nand_host_pkg

/* File: hw/nand_pin_sync.sv */
`timescale 1ns/1ps
module nand_pin_sync #(
  parameter int WIDTH = 9
) (
  input logic core_clk,
  input logic rstn,
  input logic clk_en,
  input logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;

  // Three stages; output moves only when stages two and three agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge core_clk)
      begin
        if (!rstn)
        begin
          s1_q[i] <= 1'b1;
          s2_q[i] <= 1'b1;
          s3_q[i] <= 1'b1;
          pin_out[i] <= 1'b1;
        end
        else if (clk_en)
        begin
          s1_q[i] <= pin_in[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          if (s2_q[i] == s3_q[i])
            pin_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule : nand_pin_sync
